// [verilog/slt_enable_block.sv]
// Serial bus register bank, enable sequencing and ALS threshold check
//
// Summary of operation
// - Read-only 16-bit lot id, low byte first
// - Read-only 16-bit serial number, low byte first
// - power_on starts oscillator and conversions
// - Bits 1,2 enable ALS and proximity
// - Bits 3,4 enable ALS and proximity waits
// - Temperature measured after each proximity sample
// - Bits 6,7 align integration to frame sync
// - Clearing power_on resets sequencer and persistence count only
// - Proximity sample lasts (period+1) times 88us
// - Period ignored unless above integration time
// - Flag when clear below low threshold
// - Interrupt pin follows flag when enabled
// - Low byte buffered, latched on high byte
// - Double data mode compares low byte only
// - Writable high threshold low byte
// - Flag when clear above high threshold
`timescale 1ns/10ps
`include "slt_cfg.svh"
module slt_enable_block #(
   parameter logic [6:0]  BUS_ADDR      = 7'h39,     // Arbitrary bus address
   parameter logic [15:0] LOT_ID        = 16'h0000,  // Arbitrary value
   parameter logic [15:0] SERIAL_NUMBER = 16'h0000,  // Arbitrary value
   parameter int          PROX_UNIT_CYC = `SLT_PROX_UNIT_CYC
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Serial bus pins
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   // Measurement engine
   input  wire logic [7:0]  prox_integ_time,
   input  wire logic [7:0]  prox_wait_time,
   input  wire logic        temp_done,
   input  wire logic        als_data_valid,
   input  wire logic [15:0] als_clear_data,
   input  wire logic [7:0]  als_high_thresh_msb,
   input  wire logic [3:0]  als_persistence,
   input  wire logic        double_data_mode,
   input  wire logic        als_irq_enable,
   input  wire logic        als_flag_clear,
   output logic             prox_start,
   output logic             temp_start,
   // Enables to the analog side
   output logic             osc_enable,
   output logic             als_function_enable,
   output logic             prox_detect_enable,
   output logic             als_wait_enable,
   output logic             prox_wait_enable,
   output logic             temp_measure_enable,
   output logic             als_frame_sync_enable,
   output logic             prox_frame_sync_enable,
   output logic [4:0]       bias_current_trim,
   // Threshold result
   output logic             als_threshold_flag,
   output logic             irq_output_pin
);
   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0]  bias_trim;
   logic [7:0]  function_enables;
   logic [7:0]  prox_sample_period;
   logic [7:0]  als_low_thresh_lsb;
   logic [15:0] low_thresh;
   logic [7:0]  als_high_thresh_lsb;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [1:0] scl_meta, sda_meta;
   logic       scl_s, sda_s, scl_d, sda_d;

   // Two flops first; only the second stage and later are looked at
   always_ff @(posedge clk) begin
      if (!rstn) begin
         scl_meta <= 2'h3;
         sda_meta <= 2'h3;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else begin
         scl_meta <= {scl_meta[0], scl_i};
         sda_meta <= {sda_meta[0], sda_i};
         scl_d    <= scl_s;
         sda_d    <= sda_s;
      end
   end

   wire scl_rise  = scl_s & ~scl_d;
   wire scl_fall  = ~scl_s & scl_d;
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
   assign scl_s = scl_meta[1];
   assign sda_s = sda_meta[1];

   // ----------------------------------------------------------------
   // Serial bus slave
   // ----------------------------------------------------------------
   slt_pkg::slt_bus_t bus_state, ack_from;
   logic [7:0] shreg, reg_ptr;
   logic [3:0] bit_cnt;
   logic       read_mode, nack;

   // Read mux; unmapped offsets read as zero
   function automatic logic [7:0] rd_mux(input logic [7:0] a);
      unique case (a)
         `SLT_LOT_ID_LOW:   rd_mux = LOT_ID[7:0];
         `SLT_LOT_ID_HIGH:  rd_mux = LOT_ID[15:8];
         `SLT_SERIAL_LOW:   rd_mux = SERIAL_NUMBER[7:0];
         `SLT_SERIAL_HIGH:  rd_mux = SERIAL_NUMBER[15:8];
         `SLT_BIAS_TRIM:    rd_mux = bias_trim;
         `SLT_FUNC_ENABLES: rd_mux = function_enables;
         `SLT_PROX_PERIOD:  rd_mux = prox_sample_period;
         `SLT_ALS_LO_LSB:   rd_mux = als_low_thresh_lsb;
         `SLT_ALS_LO_MSB:   rd_mux = low_thresh[15:8];
         `SLT_ALS_HI_LSB:   rd_mux = als_high_thresh_lsb;
         default:           rd_mux = 8'h00;
      endcase
   endfunction : rd_mux

   // Byte for the next read slot; always_comb also follows the registers read inside rd_mux
   logic [7:0] rd_byte;
   always_comb rd_byte = rd_mux(reg_ptr);

   wire byte_done = scl_fall & (bit_cnt == 4'h8);
   wire addr_hit  = shreg[7:1] == BUS_ADDR;
   wire ack_end   = scl_fall & (bus_state == slt_pkg::BS_ACK);
   wire wr_stb    = byte_done & (bus_state == slt_pkg::BS_WDAT);
   wire [7:0] wr_addr = reg_ptr;
   wire [7:0] wr_data = shreg;

   // Byte framing: sample on rising SCL, drive on falling SCL
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bus_state <= slt_pkg::BS_IDLE;
         ack_from  <= slt_pkg::BS_IDLE;
         shreg     <= 8'h00;
         reg_ptr   <= 8'h00;
         bit_cnt   <= 4'h0;
         read_mode <= 1'b0;
         nack      <= 1'b0;
         sda_oe    <= 1'b0;
         sda_o     <= 1'b0;
      end else if (bus_start) begin
         bus_state <= slt_pkg::BS_ADDR;
         bit_cnt   <= 4'h0;
         sda_oe    <= 1'b0;
      end else if (bus_stop) begin
         bus_state <= slt_pkg::BS_IDLE;
         sda_oe    <= 1'b0;
      end else begin
         unique case (bus_state)
            slt_pkg::BS_IDLE: ;
            slt_pkg::BS_ADDR, slt_pkg::BS_REG, slt_pkg::BS_WDAT: begin
               if (scl_rise) begin
                  shreg   <= {shreg[6:0], sda_s};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  bit_cnt  <= 4'h0;
                  ack_from <= bus_state;
                  if (bus_state == slt_pkg::BS_ADDR) begin
                     read_mode <= shreg[0];
                     bus_state <= addr_hit ? slt_pkg::BS_ACK : slt_pkg::BS_IDLE;
                     sda_oe    <= addr_hit;
                  end else begin
                     bus_state <= slt_pkg::BS_ACK;
                     sda_oe    <= 1'b1;
                     if (bus_state == slt_pkg::BS_REG) reg_ptr <= shreg;
                     else reg_ptr <= reg_ptr + 8'h01;
                  end
               end
            end
            slt_pkg::BS_ACK: begin
               if (ack_end) begin
                  if (ack_from == slt_pkg::BS_ADDR && read_mode) begin
                     bus_state <= slt_pkg::BS_RDAT;
                     shreg     <= rd_byte;
                     sda_oe    <= ~rd_byte[7];
                     reg_ptr   <= reg_ptr + 8'h01;
                  end else begin
                     bus_state <= (ack_from == slt_pkg::BS_ADDR) ? slt_pkg::BS_REG : slt_pkg::BS_WDAT;
                     sda_oe    <= 1'b0;
                  end
               end
            end
            slt_pkg::BS_RDAT: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  bit_cnt   <= 4'h0;
                  bus_state <= slt_pkg::BS_RACK;
                  sda_oe    <= 1'b0;
               end else if (scl_fall) begin
                  shreg  <= {shreg[6:0], 1'b1};
                  sda_oe <= ~shreg[6];
               end
            end
            slt_pkg::BS_RACK: begin
               if (scl_rise) begin
                  nack <= sda_s;
               end else if (scl_fall) begin
                  // Master nack ends the read burst
                  bus_state <= nack ? slt_pkg::BS_IDLE : slt_pkg::BS_RDAT;
                  shreg     <= rd_byte;
                  sda_oe    <= ~nack & ~rd_byte[7];
                  reg_ptr   <= nack ? reg_ptr : reg_ptr + 8'h01;
               end
            end
            default: bus_state <= slt_pkg::BS_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Writable registers
   // ----------------------------------------------------------------
   wire wr_lo_lsb = wr_stb & (wr_addr == `SLT_ALS_LO_LSB);
   wire wr_lo_msb = wr_stb & (wr_addr == `SLT_ALS_LO_MSB);

   // Low threshold byte waits in a buffer so the comparator never sees half a value
   always_ff @(posedge clk) begin
      if (!rstn) begin
         bias_trim           <= `SLT_BIAS_TRIM_RST;
         function_enables    <= `SLT_ENABLES_RST;
         prox_sample_period  <= `SLT_PROX_PERIOD_RST;
         als_low_thresh_lsb  <= `SLT_THRESH_RST;
         low_thresh          <= {`SLT_THRESH_RST, `SLT_THRESH_RST};
         als_high_thresh_lsb <= `SLT_THRESH_RST;
      end else if (wr_stb) begin
         if (wr_addr == `SLT_BIAS_TRIM) bias_trim <= wr_data;
         if (wr_addr == `SLT_FUNC_ENABLES) function_enables <= wr_data;
         if (wr_addr == `SLT_PROX_PERIOD) prox_sample_period <= wr_data;
         if (wr_lo_lsb) als_low_thresh_lsb <= wr_data;
         if (wr_lo_msb) low_thresh <= {wr_data, als_low_thresh_lsb};
         if (wr_addr == `SLT_ALS_HI_LSB) als_high_thresh_lsb <= wr_data;
      end
   end

   assign osc_enable             = function_enables[`SLT_EN_POWER];
   assign als_function_enable    = function_enables[`SLT_EN_ALS];
   assign prox_detect_enable     = function_enables[`SLT_EN_PROX];
   assign als_wait_enable        = function_enables[`SLT_EN_ALS_WAIT];
   assign prox_wait_enable       = function_enables[`SLT_EN_PROX_WAIT];
   assign temp_measure_enable    = function_enables[`SLT_EN_TEMP];
   assign als_frame_sync_enable  = function_enables[`SLT_EN_ALS_SYNC];
   assign prox_frame_sync_enable = function_enables[`SLT_EN_PROX_SYNC];
   assign bias_current_trim      = bias_trim[`SLT_TRIM_MSB:0];

   // ----------------------------------------------------------------
   // Proximity sequencer
   // ----------------------------------------------------------------
   slt_pkg::slt_seq_t seq_state;
   logic [15:0] pre_cnt;
   logic [7:0]  units_left;

   wire       power_on  = function_enables[`SLT_EN_POWER];
   wire       unit_tick = pre_cnt == 16'h0000;
   wire       span_done = unit_tick & (units_left == 8'h00);
   // Period only counts when it outlasts integration
   wire [7:0] prox_units = (prox_sample_period > prox_integ_time) ? prox_sample_period
                                                                  : prox_integ_time;
   wire [15:0] unit_top = 16'(PROX_UNIT_CYC - 1);

   // Clearing power_on drops the sequencer to idle; registers are untouched
   always_ff @(posedge clk) begin
      if (!rstn || !power_on) begin
         seq_state  <= slt_pkg::SQ_IDLE;
         pre_cnt    <= 16'h0000;
         units_left <= 8'h00;
         prox_start <= 1'b0;
         temp_start <= 1'b0;
      end else begin
         prox_start <= 1'b0;
         temp_start <= 1'b0;
         pre_cnt    <= unit_tick ? unit_top : pre_cnt - 16'h0001;
         if (unit_tick && units_left != 8'h00) units_left <= units_left - 8'h01;
         unique case (seq_state)
            slt_pkg::SQ_IDLE, slt_pkg::SQ_WAIT: begin
               if (prox_detect_enable && (seq_state == slt_pkg::SQ_IDLE || span_done)) begin
                  seq_state  <= slt_pkg::SQ_PROX;
                  prox_start <= 1'b1;
                  pre_cnt    <= unit_top;
                  units_left <= prox_units;
               end else if (!prox_detect_enable) begin
                  seq_state <= slt_pkg::SQ_IDLE;
               end
            end
            slt_pkg::SQ_PROX: begin
               if (span_done && temp_measure_enable) begin
                  seq_state  <= slt_pkg::SQ_TEMP;
                  temp_start <= 1'b1;
               end else if (span_done) begin
                  seq_state  <= slt_pkg::SQ_WAIT;
                  pre_cnt    <= unit_top;
                  units_left <= prox_wait_enable ? prox_wait_time : 8'h00;
               end
            end
            slt_pkg::SQ_TEMP: begin
               if (temp_done) begin
                  seq_state  <= slt_pkg::SQ_WAIT;
                  pre_cnt    <= unit_top;
                  units_left <= prox_wait_enable ? prox_wait_time : 8'h00;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // ALS threshold comparison
   // ----------------------------------------------------------------
   logic [3:0] pers_cnt;

   wire [15:0] hi_thresh = {als_high_thresh_msb, als_high_thresh_lsb};
   // Double data mode looks at the low byte alone
   wire below_low = double_data_mode ? (als_clear_data[7:0] < low_thresh[7:0])
                                     : (als_clear_data < low_thresh);
   wire above_hi  = double_data_mode ? (als_clear_data[7:0] > hi_thresh[7:0])
                                     : (als_clear_data > hi_thresh);
   wire out_range = below_low | above_hi;
   wire [3:0] hit_cnt = (pers_cnt == 4'hf) ? pers_cnt : pers_cnt + 4'h1;
   wire als_hit   = als_data_valid & out_range & (hit_cnt >= als_persistence);
   wire next_flag = als_hit | (als_threshold_flag & ~als_flag_clear);     // Set wins over clear

   // One evaluation per finished integration; persistence restarts on power off
   always_ff @(posedge clk) begin
      if (!rstn || !power_on) begin
         pers_cnt <= 4'h0;
      end else if (als_data_valid) begin
         pers_cnt <= out_range ? hit_cnt : 4'h0;
      end
   end

   // Flag and pin move together while als_irq_enable is set; otherwise the pin stays low
   always_ff @(posedge clk) begin
      if (!rstn) begin
         als_threshold_flag <= 1'b0;
         irq_output_pin     <= 1'b0;
      end else begin
         als_threshold_flag <= next_flag;
         irq_output_pin     <= next_flag & als_irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);

   power_write_a: assert property (wr_stb && wr_addr == `SLT_FUNC_ENABLES |=> osc_enable == $past(wr_data[0]))
      else $error("power_on does not follow its write");
   seq_reset_a: assert property (!power_on |=> seq_state == slt_pkg::SQ_IDLE && !prox_start)
      else $error("sequencer runs with power_on clear");
   prox_span_a: assert property (prox_start |-> units_left == $past(prox_units) && pre_cnt == unit_top)
      else $error("proximity sample span loaded wrong");
   period_ignore_a: assert property (prox_start && $past(prox_integ_time >= prox_sample_period)
                                     |-> units_left == $past(prox_integ_time))
      else $error("short period not ignored");
   temp_after_a: assert property (seq_state == slt_pkg::SQ_PROX && span_done && temp_measure_enable && power_on
                                  |=> temp_start ##1 !temp_start)
      else $error("temperature not started after proximity");
   thr_latch_a: assert property (wr_lo_msb |=> low_thresh == {$past(wr_data), $past(als_low_thresh_lsb)})
      else $error("threshold not latched as a pair");
   thr_hold_a: assert property (wr_lo_lsb |=> $stable(low_thresh))
      else $error("low byte reached comparator early");
   flag_set_a: assert property (als_data_valid && below_low && hit_cnt >= als_persistence |=> als_threshold_flag)
      else $error("low threshold crossing missed");
   irq_pin_a: assert property (irq_output_pin == (als_threshold_flag && $past(als_irq_enable)))
      else $error("interrupt pin disagrees with flag");
   no_eval_a: assert property (!als_data_valid && !als_threshold_flag && !als_flag_clear
                               |=> !als_threshold_flag)
      else $error("flag set outside an ALS cycle");
endmodule : slt_enable_block

// [verilog/slt_cfg.svh]
// Register offsets, reset values and timing counts of the sensor enable block
`ifndef SLT_CFG_SVH
`define SLT_CFG_SVH
// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define SLT_LOT_ID_LOW      8'h07
`define SLT_LOT_ID_HIGH     8'h08
`define SLT_SERIAL_LOW      8'h09
`define SLT_SERIAL_HIGH     8'h0a
`define SLT_BIAS_TRIM       8'h1a
`define SLT_FUNC_ENABLES    8'h80
`define SLT_PROX_PERIOD     8'h82
`define SLT_ALS_LO_LSB      8'h84
`define SLT_ALS_LO_MSB      8'h85
`define SLT_ALS_HI_LSB      8'h86
// ----------------------------------------------------------------
// Field positions of function_enables
// ----------------------------------------------------------------
`define SLT_EN_POWER        0
`define SLT_EN_ALS          1
`define SLT_EN_PROX         2
`define SLT_EN_ALS_WAIT     3
`define SLT_EN_PROX_WAIT    4
`define SLT_EN_TEMP         5
`define SLT_EN_ALS_SYNC     6
`define SLT_EN_PROX_SYNC    7
`define SLT_TRIM_MSB        4
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLT_BIAS_TRIM_RST   8'h07
`define SLT_ENABLES_RST     8'h00
`define SLT_PROX_PERIOD_RST 8'h1f
`define SLT_THRESH_RST      8'h00
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SLT_CLK_NS          100
`define SLT_PROX_UNIT_NS    88000
`define SLT_PROX_UNIT_CYC   ((`SLT_PROX_UNIT_NS + `SLT_CLK_NS - 1) / `SLT_CLK_NS)
`endif

// [verilog/slt_pkg.sv]
// Types shared by the sensor enable block
package slt_pkg;
   // Measurement sequencer states
   typedef enum logic [1:0] {SQ_IDLE, SQ_PROX, SQ_TEMP, SQ_WAIT} slt_seq_t;
   // Serial bus slave states
   typedef enum logic [2:0] {BS_IDLE, BS_ADDR, BS_REG, BS_WDAT, BS_ACK, BS_RDAT, BS_RACK} slt_bus_t;
endpackage : slt_pkg

// [tb/slt_host.sv]
// Serial bus controller model standing in for the host processor
`timescale 1ns/10ps
module slt_host #(
   parameter logic [6:0] DEV_ADDR = 7'h39
) (
   // Clock
   input  wire logic clk,
   // Bus wires
   output logic      scl,
   output logic      sda_oe,
   input  wire logic sda,
   // Missing device acknowledges
   output int        naks
);
   // ----------------------------------------------------------------
   // Bit and frame level, SCL period 800 ns
   // ----------------------------------------------------------------
   // Idle bus: SCL and SDA both released high
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
      naks = 0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   // Data moves only while SCL is low, so no false START or STOP
   task automatic xb(input logic b, output logic r);
      scl <= 1'b0;
      tick(3);
      sda_oe <= ~b;
      tick(1);
      scl <= 1'b1;
      tick(4);
      r = sda;
   endtask : xb
   // START when stop is 0, STOP when stop is 1
   task automatic frame(input logic stop);
      scl <= 1'b0;
      tick(3);
      sda_oe <= stop;
      tick(1);
      scl <= 1'b1;
      tick(4);
      sda_oe <= ~stop;
      tick(4);
   endtask : frame
   // One byte plus the acknowledge slot, which is always released here
   task automatic xbyte(input logic [7:0] d, input logic dev_ack, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) xb(d[i], q[i]);
      xb(1'b1, a);
      if (dev_ack && a !== 1'b0) naks++;
   endtask : xbyte
   // Register write: pointer then one data byte
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      frame(1'b0);
      xbyte({DEV_ADDR, 1'b0}, 1'b1, q);
      xbyte(a, 1'b1, q);
      xbyte(d, 1'b1, q);
      frame(1'b1);
   endtask : wr
   // Register read through a repeated START, last byte not acknowledged
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] q;
      frame(1'b0);
      xbyte({DEV_ADDR, 1'b0}, 1'b1, q);
      xbyte(a, 1'b1, q);
      frame(1'b0);
      xbyte({DEV_ADDR, 1'b1}, 1'b1, q);
      xbyte(8'hff, 1'b0, d);
      frame(1'b1);
   endtask : rd
endmodule : slt_host

// [tb/tb_top.sv]
// Self-checking bench of the sensor enable block
`timescale 1ns/10ps
`include "slt_cfg.svh"
module tb_top;
   localparam int          UNIT = 4;
   localparam logic [15:0] LOT  = 16'h5a3c;  // Arbitrary value
   localparam logic [15:0] SER  = 16'hc3a5;  // Arbitrary value
   localparam logic [7:0]  RA [11] = '{8'h07, 8'h08, 8'h09, 8'h0a, 8'h1a, 8'h80, 8'h82, 8'h84, 8'h85, 8'h86, 8'h50};
   localparam logic [7:0]  RE [11] = '{LOT[7:0], LOT[15:8], SER[7:0], SER[15:8], 8'h07, 8'h00, 8'h1f, 8'h00, 8'h00,
                                       8'h00, 8'h00};
   logic        clk, rstn, scl, host_oe, sda_o, sda_oe, temp_done, adv, ddm, irq_en, fclr;
   logic        prox_start, temp_start, flag, irq;
   logic [7:0]  integ, pwait, hmsb, q;
   wire  [7:0]  en;
   logic [15:0] clear;
   logic [3:0]  pers;
   logic [4:0]  trim;
   int          errors, tests_run, cyc, naks;
   // Open-drain wire with pull-up
   wire sda = (sda_oe ? sda_o : 1'b1) & ~host_oe;
   slt_enable_block #(.LOT_ID(LOT), .SERIAL_NUMBER(SER), .PROX_UNIT_CYC(UNIT)) i_dut (
      .clk(clk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
      .prox_integ_time(integ), .prox_wait_time(pwait), .temp_done(temp_done), .als_data_valid(adv),
      .als_clear_data(clear), .als_high_thresh_msb(hmsb), .als_persistence(pers), .double_data_mode(ddm),
      .als_irq_enable(irq_en), .als_flag_clear(fclr), .prox_start(prox_start), .temp_start(temp_start),
      .osc_enable(en[0]), .als_function_enable(en[1]), .prox_detect_enable(en[2]), .als_wait_enable(en[3]),
      .prox_wait_enable(en[4]), .temp_measure_enable(en[5]), .als_frame_sync_enable(en[6]),
      .prox_frame_sync_enable(en[7]), .bias_current_trim(trim), .als_threshold_flag(flag), .irq_output_pin(irq));
   slt_host i_host (.clk(clk), .scl(scl), .sda_oe(host_oe), .sda(sda), .naks(naks));
   // ----------------------------------------------------------------
   // Clock, watchdog and reporting
   // ----------------------------------------------------------------
   // 100 ns clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // A hung wait ends the run instead of stalling it
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   // One ALS result, judged two edges later since the flag is sticky
   task automatic als(input logic [15:0] v, input logic f, input logic i);
      @(posedge clk);
      adv <= 1'b1;
      clear <= v;
      @(posedge clk);
      adv <= 1'b0;
      i_host.tick(2);
      chk(flag, f, "threshold flag");
      chk(irq, i, "irq pin");
   endtask : als
   // Power up with settling time, then enable functions
   task automatic power_up(input logic [7:0] v);
      i_host.wr(8'h80, 8'h01);
      chk(en, 8'h01, "power only");
      i_host.tick(1000);
      i_host.wr(8'h80, v);
   endtask : power_up
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk(trim, 5'b00111, "trim reset");
      for (int k = 0; k < 11; k++) begin
         i_host.rd(RA[k], q);
         chk(q, RE[k], "reset value or id");
      end
      i_host.wr(8'h07, 8'hff);
      i_host.rd(8'h07, q);
      chk(q, LOT[7:0], "lot id read-only");
      i_host.wr(8'h1a, 8'h03);
      chk(trim, 5'b00011, "trim output");
   endtask : t_reset
   task automatic t_enables();
      power_up(8'hff);
      chk(en, 8'hff, "all enables");
      i_host.wr(8'h80, 8'h00);
      chk(en, 8'h00, "enables cleared");
   endtask : t_enables
   // Sample length measured from prox_start to the following temp_start
   task automatic t_prox(input logic [7:0] it, input logic [7:0] per);
      int n;
      integ <= it;
      i_host.wr(8'h82, per);
      power_up(8'h25);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prox_start !== 1'b1 && n < 2000);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (temp_start !== 1'b1 && n < 2000);
      chk(n, ((it > per ? it : per) + 1) * UNIT, "sample length");
      i_host.wr(8'h80, 8'h00);
      i_host.rd(8'h82, q);
      chk(q, per, "period kept");
   endtask : t_prox
   task automatic t_thresh();
      i_host.wr(8'h86, 8'hff);
      i_host.wr(8'h84, 8'h34);
      i_host.rd(8'h84, q);
      chk(q, 8'h34, "low byte buffer");
      i_host.rd(8'h85, q);
      chk(q, 8'h00, "not yet latched");
      i_host.wr(8'h84, 8'h34);
      i_host.wr(8'h85, 8'h12);
      power_up(8'h03);
      als(16'h1234, 1'b0, 1'b0);
      als(16'h1233, 1'b1, 1'b1);
      fclr <= 1'b1;
      irq_en <= 1'b0;
      hmsb <= 8'h20;
      @(posedge clk);
      fclr <= 1'b0;
      als(16'h20ff, 1'b0, 1'b0);
      als(16'h2100, 1'b1, 1'b0);
      // Double data mode: low bytes only, upper threshold bytes zero
      fclr <= 1'b1;
      i_host.wr(8'h80, 8'h00);
      fclr <= 1'b0;
      ddm <= 1'b1;
      hmsb <= 8'h00;
      i_host.wr(8'h84, 8'h34);
      i_host.wr(8'h85, 8'h00);
      power_up(8'h03);
      als(16'h1235, 1'b0, 1'b0);
      als(16'h1233, 1'b1, 1'b0);
      chk(naks, 0, "device acknowledges");
   endtask : t_thresh
   // Main sequence
   initial begin
      {rstn, temp_done, adv, ddm, fclr, clear, integ, pwait} = '0;
      {irq_en, hmsb, pers} = {1'b1, 8'hff, 4'h1};
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      i_host.tick(3);
      temp_done <= 1'b1;
      t_reset();
      t_enables();
      t_prox(8'h00, 8'h02);
      t_prox(8'h05, 8'h02);
      t_thresh();
      tally_and_finish();
   end
endmodule : tb_top
